// ===== aeqs_cfg.svh
// Offsets, field positions, reset values and timing counts for the equalizer status bank
`ifndef AEQS_CFG_SVH
`define AEQS_CFG_SVH
`define AEQS_OFS_RESULT        8'h50
`define AEQS_OFS_QUALITY       8'h51
`define AEQS_RST_RESULT        8'h80
`define AEQS_RST_QUALITY       8'h00
`define AEQS_BIT_DONE          7
`define AEQS_BIT_OVF           6
`define AEQS_BIT_DACW          4
`define AEQS_HC_W              13
`define AEQS_EYE_MAX           4'hF
`define AEQS_DACW_TIME_NS      1000
`define AEQS_CLK_PERIOD_NS     10
`define AEQS_DACW_CYC          (`AEQS_DACW_TIME_NS / `AEQS_CLK_PERIOD_NS)
`define AEQS_RUN_CYC           16
`endif

// ===== aeqs_hit_counter.sv
// Saturating-free 13-bit hit counter with sticky overflow
`timescale 1ns/1ps
`default_nettype none
`include "aeqs_cfg.svh"
module aeqs_hit_counter
	import aeqs_pkg::*;
(
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_clear,
	input  wire logic i_hit,
	// Status
	output logic      o_overflow
);
	logic [`AEQS_HC_W-1:0] count_q;
	logic                  ovf_q;
	wire                   wrap = i_hit && (&count_q);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || i_clear) begin
			count_q <= '0;
			ovf_q   <= 1'b0;
		end else begin
			if (i_hit) count_q <= count_q + 1'b1;
			if (wrap) ovf_q <= 1'b1;
		end
	end
	assign o_overflow = ovf_q;
	AST_HC_OVF: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(wrap && !i_clear) |=> ovf_q) else $error("overflow not flagged on wrap");
endmodule
`default_nettype wire

// ===== aeqs_pkg.sv
// Types shared by the equalizer status bank
package aeqs_pkg;
	typedef enum logic [1:0] {
		AEQS_IDLE,
		AEQS_DACWAIT,
		AEQS_SEARCH
	} aeqs_state_e;
	typedef logic [7:0] aeqs_byte_t;
endpackage

// ===== aeqs_search_model.sv
// Search engine stand-in feeding hits and results to the status bank
`timescale 1ns/1ps
`default_nettype none
module aeqs_search_model (
	// Clock and command
	input  wire logic        i_core_clk,
	input  wire logic        i_go,
	input  wire logic [13:0] i_hits,
	input  wire logic [3:0]  i_code,
	input  wire logic [2:0]  i_swing,
	input  wire logic [3:0]  i_eye,
	// Toward the bank
	output logic             o_hit,
	output logic             o_done,
	output logic      [3:0]  o_code,
	output logic      [2:0]  o_swing,
	output logic      [3:0]  o_eye
);
	initial begin
		{o_hit, o_done, o_code, o_swing, o_eye} = '0;
	end
	always @(posedge i_core_clk) begin
		if (i_go) begin
			repeat (i_hits) begin
				o_hit <= 1'b1;
				@(posedge i_core_clk);
			end
			o_hit <= 1'b0;
			o_done <= 1'b1;
			{o_code, o_swing, o_eye} <= {i_code, i_swing, i_eye};
			@(posedge i_core_clk);
			// Results mean nothing off the pulse, so scramble them
			o_done <= 1'b0;
			{o_code, o_swing, o_eye} <= ~{i_code, i_swing, i_eye};
		end
	end
endmodule
`default_nettype wire

// ===== aeqs_status_regs.sv
// Adaptive equalizer status register bank, read port and run sequencer
`timescale 1ns/1ps
`default_nettype none
`include "aeqs_cfg.svh"
module aeqs_status_regs
	import aeqs_pkg::*;
(
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Register read port from the serial slave
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_rd,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	// Equalizer control
	input  wire logic       i_link_training,
	input  wire logic       i_adaptive_eq_enable,
	input  wire logic       i_forced_eq_run_request,
	input  wire logic       i_forced_eq_run_bit_set,
	input  wire logic [3:0] i_over_equalization_offset,
	// Search engine results
	input  wire logic       i_eq_hit,
	input  wire logic [3:0] i_search_eq_code,
	input  wire logic [2:0] i_search_swing_range,
	input  wire logic [3:0] i_search_eye_score,
	input  wire logic       i_search_done,
	// Status out
	output logic            o_forced_eq_run_bit,
	output logic            o_eq_run_done_flag
);
	aeqs_state_e state_q;
	logic [7:0]  dacw_cnt_q;
	logic        done_q;
	logic        dacw_done_q;
	logic [3:0]  code_q;
	logic [2:0]  swing_q;
	logic [3:0]  eye_q;
	logic        force_q;
	logic [7:0]  rdata_q;
	logic        rvalid_q;
	logic        hc_ovf;
	// Start when training with enable, or on a forced request while the forced run bit is set
	wire start_train = i_link_training && i_adaptive_eq_enable;
	wire start_force = i_forced_eq_run_request && force_q;
	wire start       = (state_q == AEQS_IDLE) && (start_train || start_force);
	wire dacw_expire = (state_q == AEQS_DACWAIT) && (dacw_cnt_q == 8'(`AEQS_DACW_CYC - 1));
	wire run_end     = (state_q == AEQS_SEARCH) && i_search_done;
	// Offset applied and clamped so the code never wraps past its field
	wire [4:0] eq_sum  = {1'b0, i_search_eq_code} + {1'b0, i_over_equalization_offset};
	wire [3:0] eq_adj  = eq_sum[4] ? 4'hF : eq_sum[3:0];
	wire [3:0] eye_cap = (i_search_eye_score > `AEQS_EYE_MAX) ? `AEQS_EYE_MAX : i_search_eye_score;
	// Read mux, reserved bits tied to zero
	wire [7:0] res_word = {done_q, hc_ovf, 1'b0, dacw_done_q, code_q};
	wire [7:0] qual_word = {1'b0, swing_q, eye_q};
	wire hit_result  = (i_reg_addr == `AEQS_OFS_RESULT);
	wire hit_quality = (i_reg_addr == `AEQS_OFS_QUALITY);
	wire [7:0] rd_mux = hit_result ? res_word : (hit_quality ? qual_word : 8'h00);
	// Hits outside the search phase are ignored so a stale overflow cannot leak in
	aeqs_hit_counter u_hc (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_clear    (start),
		.i_hit      (i_eq_hit && (state_q == AEQS_SEARCH)),
		.o_overflow (hc_ovf)
	);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q <= AEQS_IDLE;
			dacw_cnt_q <= '0;
		end else begin
			unique case (state_q)
				AEQS_IDLE: begin
					if (start) state_q <= AEQS_DACWAIT;
					dacw_cnt_q <= '0;
				end
				AEQS_DACWAIT: begin
					dacw_cnt_q <= dacw_cnt_q + 8'h01;
					if (dacw_expire) state_q <= AEQS_SEARCH;
				end
				AEQS_SEARCH: begin
					if (i_search_done) state_q <= AEQS_IDLE;
				end
				default: state_q <= AEQS_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			done_q      <= 1'b1;
			dacw_done_q <= 1'b0;
			force_q     <= 1'b0;
		end else begin
			if (start) done_q <= 1'b0;
			else if (run_end) done_q <= 1'b1;
			if (start) dacw_done_q <= 1'b0;
			else if (dacw_expire) dacw_done_q <= 1'b1;
			// Set beats the hardware clear
			if (i_forced_eq_run_bit_set) force_q <= 1'b1;
			else if (run_end) force_q <= 1'b0;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			code_q  <= '0;
			swing_q <= '0;
			eye_q   <= '0;
		end else if (run_end) begin
			code_q  <= eq_adj;
			swing_q <= i_search_swing_range;
			eye_q   <= eye_cap;
		end
	end
	// Writes are deliberately not decoded; every field is status only
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_reg_rd;
			if (i_reg_rd) rdata_q <= rd_mux;
		end
	end
	assign o_reg_rdata         = rdata_q;
	assign o_reg_rvalid        = rvalid_q;
	assign o_forced_eq_run_bit = force_q;
	assign o_eq_run_done_flag  = done_q;
	AST_DONE_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		start |=> !done_q) else $error("done not low after start");
	AST_DONE_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		run_end |=> done_q) else $error("done not high after run");
	AST_FORCE_CLR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(run_end && !i_forced_eq_run_bit_set) |=> !force_q) else $error("force bit kept");
	AST_DACW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(start ##1 !dacw_done_q [*8]) |-> (state_q == AEQS_DACWAIT))
		else $error("dac wait done too early");
	AST_CODE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		run_end |=> code_q == $past(eq_adj)) else $error("code not latched");
	AST_OFFSET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(run_end && !eq_sum[4]) |=> code_q == $past(i_search_eq_code + i_over_equalization_offset))
		else $error("offset not included");
	AST_SWING: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		run_end |=> swing_q == $past(i_search_swing_range)) else $error("swing not latched");
	AST_EYE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		run_end |=> eye_q == $past(eye_cap)) else $error("eye not latched");
	AST_RD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && hit_quality) |=> (o_reg_rvalid && !o_reg_rdata[7]))
		else $error("reserved bit nonzero");
	// Reset value of the done flag, checked with reset itself as the trigger
	AST_DONE_RST: assert property (@(posedge i_core_clk)
		!i_rst_n |=> (done_q && !force_q))
		else $error("done flag not set by reset");
	// Done stays low for the whole run
	AST_DONE_BUSY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state_q != AEQS_IDLE) |-> !done_q)
		else $error("done high during run");
	// Forced request bit only drops at run end
	AST_FORCE_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(force_q && !run_end) |=> force_q)
		else $error("force bit lost early");
	// Wait flag may only rise right after a cycle in the DAC wait state
	AST_DACW_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(dacw_done_q) |-> ($past(state_q) == AEQS_DACWAIT))
		else $error("dac wait flag set outside wait");
	// Overflow bit on the bus follows the counter's sticky flag
	AST_OVF_BIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && hit_result) |=> (o_reg_rdata[6] == $past(hc_ovf)))
		else $error("overflow bit wrong on read");
	// Reserved bit 5 of the result word reads zero
	AST_RSV_RES: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && hit_result) |=> !o_reg_rdata[5])
		else $error("reserved result bit nonzero");
	// Host writes never move the result fields
	AST_WR_IGN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_wr && !run_end) |=> ($stable(code_q) && $stable(swing_q) && $stable(eye_q)))
		else $error("write altered status");
	// Unmapped addresses return zero
	AST_UNMAPPED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg_rd && !hit_result && !hit_quality) |=> (o_reg_rdata == 8'h00))
		else $error("unmapped read nonzero");
	// Every read strobe gets a valid pulse on the next cycle
	AST_RVALID: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	COV_RUN: cover property (@(posedge i_core_clk) start ##[1:300] run_end);
	COV_DACW: cover property (@(posedge i_core_clk) $rose(dacw_done_q));
	COV_FORCE: cover property (@(posedge i_core_clk) start_force && start);
	COV_OVF: cover property (@(posedge i_core_clk) $rose(hc_ovf));
	COV_WR: cover property (@(posedge i_core_clk) i_reg_wr && hit_result);
endmodule
`default_nettype wire

// ===== aeqs_status_regs_bench.sv
// Self-checking bench for the equalizer status bank
`timescale 1ns/1ps
`default_nettype none
module aeqs_status_regs_bench;
	logic        clk, rst_n, rd, wr, trn, ena, req, fset, go, rv, hit, sdone, fbit, dflag;
	logic [7:0]  addr, rdat, wdat;
	logic [13:0] nhit;
	logic [3:0]  ofs, code, eye, scode, seye;
	logic [2:0]  sw, ssw;
	int          fail_count, cmp_count, n;
	aeqs_status_regs i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_rd(rd),
		.i_reg_wr(wr), .i_reg_wdata(wdat), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
		.i_link_training(trn), .i_adaptive_eq_enable(ena), .i_forced_eq_run_request(req),
		.i_forced_eq_run_bit_set(fset), .i_over_equalization_offset(ofs), .i_eq_hit(hit),
		.i_search_eq_code(scode), .i_search_swing_range(ssw), .i_search_eye_score(seye),
		.i_search_done(sdone), .o_forced_eq_run_bit(fbit), .o_eq_run_done_flag(dflag));
	aeqs_search_model i_srch (.i_core_clk(clk), .i_go(go), .i_hits(nhit), .i_code(code),
		.i_swing(sw), .i_eye(eye), .o_hit(hit), .o_done(sdone), .o_code(scode),
		.o_swing(ssw), .o_eye(seye));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_for(input int lim);
		for (n = 0; n < lim && (rv !== 1'b1 && dflag !== 1'b1 || rd); n++) @(posedge clk) #1;
		if (n == lim) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) addr <= a;
		rd <= 1'b1;
		@(posedge clk) rd <= 1'b0;
		#1;
		for (n = 0; n < 4 && rv !== 1'b1; n++) @(posedge clk) #1;
		if (n == 4) begin
			fail_count++;
			stop_test();
		end
		chk(rdat, exp);
	endtask
	task automatic wr_reg(input logic [7:0] a);
		@(posedge clk) addr <= a;
		wr <= 1'b1;
		@(posedge clk) wr <= 1'b0;
	endtask
	// One run: search is released only after the DAC wait has had time
	task automatic run(input logic forced, input logic [3:0] prev, input logic [7:0] r0,
		input logic [7:0] r1);
		@(posedge clk) trn <= !forced;
		fset <= forced;
		@(posedge clk) trn <= 1'b0;
		fset <= 1'b0;
		#1 chk({7'h00, fbit}, {7'h00, forced});
		repeat (88) @(posedge clk);
		rd_reg(8'h50, {4'h0, prev});
		repeat (10) @(posedge clk);
		rd_reg(8'h50, {4'h1, prev});
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		#1;
		for (n = 0; n < 9000 && dflag !== 1'b1; n++) @(posedge clk) #1;
		if (n == 9000) begin
			fail_count++;
			stop_test();
		end
		chk({7'h00, fbit}, 8'h00);
		rd_reg(8'h50, r0);
		rd_reg(8'h51, r1);
	endtask
	initial begin
		{rst_n, rd, wr, trn, ena, req, fset, go} = '0;
		{addr, ofs, nhit, code, sw, eye, fail_count, cmp_count} = '0;
		wdat = 8'hFF;
		repeat (8) @(posedge clk);
		// Supplies assumed stable, enable raised after reset
		rst_n <= 1'b1;
		ena <= 1'b1;
		rd_reg(8'h50, 8'h80);
		rd_reg(8'h51, 8'h00);
		rd_reg(8'h52, 8'h00);
		$display("test reset values done");
		ofs <= 4'h3;
		{nhit, code, sw, eye} <= {14'h0005, 4'h9, 3'h5, 4'hF};
		run(1'b0, 4'h0, 8'h9C, 8'h5F);
		$display("test training run done");
		req <= 1'b1;
		{nhit, code, sw, eye} <= {14'h2008, 4'hE, 3'h2, 4'h7};
		run(1'b1, 4'hC, 8'hDF, 8'h27);
		$display("test forced run done");
		wr_reg(8'h50);
		wr_reg(8'h51);
		rd_reg(8'h50, 8'hDF);
		rd_reg(8'h51, 8'h27);
		$display("test write ignore done");
		stop_test();
	end
endmodule
`default_nettype wire
